// file: rtl/acc_map.svh
// Offsets, field positions, reset values and timing counts of the converter control block
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ==========================================================
// Register map
// ==========================================================
`define ACC_CTL_OFFSET 8'h00
`define ACC_CTL_RESET 8'h00

// ==========================================================
// Field positions in converter_control_status
// ==========================================================
`define ACC_BIT_ENABLE 7
`define ACC_BIT_TRACK_MODE 6
`define ACC_BIT_COMPLETE 5
`define ACC_BIT_BUSY 4
`define ACC_BIT_WINDOW 3
`define ACC_SRC_MSB 2
`define ACC_SRC_LSB 0

// ==========================================================
// Timing counts in converter clock periods, and the clk_i cycles per converter clock
// ==========================================================
`define ACC_TRACK_SAR_CLKS 3
`define ACC_CONV_SAR_CLKS 11
`define ACC_SAR_DIV 4

`endif

// file: rtl/acc_pkg.sv
// Types shared by the converter control block
`default_nettype none

package acc_pkg;

  // ==========================================================
  // Register layout, bit 7 down to bit 0
  // ==========================================================
  typedef struct packed {
    logic enable;      // Converter enable
    logic track_mode;  // Low-power track mode select
    logic complete;    // Conversion complete flag
    logic busy;        // Conversion busy
    logic window;      // Window match flag
    logic [2:0] src;   // Start source select
  } acc_ctl_t;

  // ==========================================================
  // Start source codes
  // ==========================================================
  typedef enum logic [2:0] {
    SRC_SOFTWARE = 3'h0,
    SRC_TIMER0 = 3'h1,
    SRC_TIMER2 = 3'h2,
    SRC_TIMER1 = 3'h3,
    SRC_EXT_PIN = 3'h4,
    SRC_TIMER3 = 3'h5
  } acc_src_t;

  // ==========================================================
  // Timer overflow pulses
  // ==========================================================
  typedef struct packed {
    logic t3;
    logic t2;
    logic t1;
    logic t0;
  } acc_ovf_t;

  // ==========================================================
  // Sequencer states, one-hot
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_TRACK = 3'h2,
    ST_CONV = 3'h4
  } acc_state_t;

endpackage

`default_nettype wire

// file: rtl/acc_sar_tick.sv
// Converter clock enable divider
`timescale 1ns/1ps
`default_nettype none

module acc_sar_tick #(
  parameter int DIV = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic tick_o
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_r;   // Cycle counter
  logic [CW-1:0] cnt_nxt;
  logic tick_nxt;         // One-cycle enable

  // ==========================================================
  // Divider next state
  // ==========================================================
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (!run_i) begin
      // Restart so each sequence sees full periods
      cnt_nxt = '0;
    end else if (cnt_r == CW'(DIV - 1)) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end

endmodule

`default_nettype wire

// file: rtl/acc_conv_ctrl.sv
// Conversion control and status logic for the successive-approximation converter
// Contract
// - Enable clear holds converter in shutdown
// - Normal mode tracks except while converting
// - Low-power mode tracks per start source
// - Complete flag set as busy falls
// - Complete flag sticky until cleared
// - Busy reads one during conversion
// - Window flag set on match at conversion end, sticky
// - Other normal sources start on timer overflow
// - Low-power trigger starts tracking period first, except pin source
// - Tracking lasts three converter clocks
// - Pin source tracks low in low-power mode, converts rising
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.svh"

module acc_conv_ctrl #(
  parameter int AW = 8,
  parameter int SAR_DIV = `ACC_SAR_DIV,
  parameter int TRACK_CLKS = `ACC_TRACK_SAR_CLKS,
  parameter int CONV_CLKS = `ACC_CONV_SAR_CLKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire acc_pkg::acc_ovf_t timer_ovf_i,
  input wire logic ext_start_i,
  input wire logic win_match_i,
  output logic shutdown_o,
  output logic track_o,
  output logic convert_o,
  output logic conv_done_o
);

  import acc_pkg::*;

  localparam int CW = $clog2(CONV_CLKS + TRACK_CLKS + 1);

  // ==========================================================
  // Trigger selection
  // ==========================================================
  function automatic logic sel_trigger(input logic [2:0] src, input acc_ovf_t ovf,
                                       input logic pin_rise, input logic sw_go);
    logic hit;
    hit = 1'b0;
    case (src)
      SRC_SOFTWARE: hit = sw_go;
      SRC_TIMER0: hit = ovf.t0;
      SRC_TIMER2: hit = ovf.t2;
      SRC_TIMER1: hit = ovf.t1;
      SRC_EXT_PIN: hit = pin_rise;
      SRC_TIMER3: hit = ovf.t3;
      default: hit = 1'b0; // Reserved codes start nothing
    endcase
    return hit;
  endfunction

  // ==========================================================
  // Bus slave state
  // ==========================================================
  logic ack_nxt;            // Next acknowledge
  logic [31:0] dat_nxt;     // Next read data
  logic bus_req;            // New request this cycle
  logic bus_hit;            // Address hits the register
  logic reg_wr;             // Write to the register lane

  // ==========================================================
  // Control state
  // ==========================================================
  acc_ctl_t ctl_r;          // converter_control_status
  acc_ctl_t ctl_nxt;
  acc_state_t st_r;         // Sequencer state
  acc_state_t st_nxt;
  logic [CW-1:0] cnt_r;     // Converter clock counter
  logic [CW-1:0] cnt_nxt;
  logic pin_prev_r;         // Pin level one cycle ago
  logic pin_prev_nxt;
  logic shutdown_nxt;
  logic track_nxt;
  logic convert_nxt;
  logic done_nxt;
  logic sar_tick;           // Converter clock enable
  logic sw_go;              // Software start request
  logic pin_rise;           // Rising edge of start pin
  logic trig;               // Selected start event
  logic [7:0] wdat;         // Written byte

  // ==========================================================
  // Converter clock divider
  // ==========================================================
  acc_sar_tick #(
    .DIV(SAR_DIV)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    // Runs from the trigger cycle so the first tick is one full period
    .run_i(st_nxt != ST_IDLE),
    .tick_o(sar_tick)
  );

  // ==========================================================
  // Wishbone decode and answer
  // ==========================================================
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    bus_hit = (wb_adr_i == AW'(`ACC_CTL_OFFSET));
    reg_wr = bus_req && bus_hit && wb_we_i && wb_sel_i[0];
    ack_nxt = bus_req;
    dat_nxt = wb_dat_o;
    if (bus_req) begin
      // Unmapped addresses read zero
      dat_nxt = bus_hit ? {24'h0, ctl_r} : 32'h0;
    end
  end

  // Bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= ack_nxt;
      wb_dat_o <= dat_nxt;
    end
  end

  // ==========================================================
  // Control next state
  // ==========================================================
  always_comb begin
    wdat = wb_dat_i[7:0];
    ctl_nxt = ctl_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    pin_prev_nxt = ext_start_i;
    pin_rise = ext_start_i && !pin_prev_r;
    // Busy write of one only counts with software source
    sw_go = reg_wr && wdat[`ACC_BIT_BUSY] && (ctl_r.src == SRC_SOFTWARE);
    trig = sel_trigger(ctl_r.src, timer_ovf_i, pin_rise, sw_go);
    if (reg_wr) begin
      ctl_nxt.enable = wdat[`ACC_BIT_ENABLE];
      ctl_nxt.track_mode = wdat[`ACC_BIT_TRACK_MODE];
      ctl_nxt.src = wdat[`ACC_SRC_MSB:`ACC_SRC_LSB];
      // Writing zero clears, writing one
      ctl_nxt.complete = ctl_r.complete && wdat[`ACC_BIT_COMPLETE];
      ctl_nxt.window = ctl_r.window && wdat[`ACC_BIT_WINDOW];
    end
    case (st_r)
      ST_IDLE: begin
        cnt_nxt = '0;
        if (ctl_r.enable && trig) begin
          if (ctl_r.track_mode && ctl_r.src != SRC_EXT_PIN) begin
            // Trigger opens a timed tracking period
            st_nxt = ST_TRACK;
          end else begin
            // Normal mode and pin edge convert at once
            st_nxt = ST_CONV;
          end
        end
      end
      ST_TRACK: begin
        if (sar_tick) begin
          if (cnt_r == CW'(TRACK_CLKS - 1)) begin
            // Tracking done, conversion follows
            st_nxt = ST_CONV;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + CW'(1);
          end
        end
      end
      ST_CONV: begin
        if (sar_tick) begin
          if (cnt_r == CW'(CONV_CLKS - 1)) begin
            st_nxt = ST_IDLE;
            cnt_nxt = '0;
            done_nxt = 1'b1;
            // Set after the software clear so the set wins
            ctl_nxt.complete = 1'b1;
            if (win_match_i) begin
              ctl_nxt.window = 1'b1;
            end
          end else begin
            cnt_nxt = cnt_r + CW'(1);
          end
        end
      end
      default: begin
        st_nxt = ST_IDLE;
        cnt_nxt = '0;
      end
    endcase
    if (!ctl_nxt.enable) begin
      // Disable aborts any sequence
      st_nxt = ST_IDLE;
      cnt_nxt = '0;
      done_nxt = 1'b0;
    end
    // Busy mirrors a running sequence
    ctl_nxt.busy = (st_nxt != ST_IDLE);
    shutdown_nxt = !ctl_nxt.enable;
    convert_nxt = (st_nxt == ST_CONV);
    if (!ctl_nxt.enable || st_nxt == ST_CONV) begin
      track_nxt = 1'b0;
    end else if (!ctl_nxt.track_mode) begin
      track_nxt = 1'b1;
    end else if (ctl_nxt.src == SRC_EXT_PIN) begin
      track_nxt = !ext_start_i && (st_nxt == ST_IDLE);
    end else begin
      track_nxt = (st_nxt == ST_TRACK);
    end
  end

  // Control registers, zero at reset except st_r (ST_IDLE) and shutdown_o (one)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= acc_ctl_t'(`ACC_CTL_RESET);
      st_r <= ST_IDLE;
      cnt_r <= '0;
      pin_prev_r <= 1'b0;
      shutdown_o <= 1'b1;
      track_o <= 1'b0;
      convert_o <= 1'b0;
      conv_done_o <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      pin_prev_r <= pin_prev_nxt;
      shutdown_o <= shutdown_nxt;
      track_o <= track_nxt;
      convert_o <= convert_nxt;
      conv_done_o <= done_nxt;
    end
  end

endmodule

`default_nettype wire

// file: dv/acc_conv_ctrl_properties.sv
// Port-level assertions of the converter control block
`timescale 1ns/1ps
`default_nettype none

module acc_conv_ctrl_properties #(
  parameter int SAR_DIV = 4,
  parameter int CONV_CLKS = 11
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic shutdown_o,
  input wire logic track_o,
  input wire logic convert_o,
  input wire logic conv_done_o
);
  // ==========
  // Conversion length counter
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  // Counts cycles with convert high
  always_comb begin
    cnt_nxt = convert_o ? cnt_r + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk_i) begin
    cnt_r <= rst_i ? 16'h0 : cnt_nxt;
  end
  // ==========
  // Assertions
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  done_on_fall_a: assert property (conv_done_o |-> $fell(convert_o))
    else $error("done without convert end");
  done_pulse_a: assert property (conv_done_o |=> !conv_done_o)
    else $error("done pulse too long");
  conv_len_a: assert property (conv_done_o |-> cnt_r == CONV_CLKS * SAR_DIV)
    else $error("conversion length wrong");
  track_excl_a: assert property (convert_o |-> !track_o)
    else $error("tracking while converting");
  shut_quiet_a: assert property (shutdown_o |-> !convert_o && !track_o && !conv_done_o)
    else $error("activity in shutdown");
endmodule

bind acc_conv_ctrl acc_conv_ctrl_properties #(.SAR_DIV(SAR_DIV), .CONV_CLKS(CONV_CLKS)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .shutdown_o(shutdown_o), .track_o(track_o), .convert_o(convert_o),
  .conv_done_o(conv_done_o));
`default_nettype wire

// file: dv/acc_trig_model.sv
// Timer overflow and window comparator stand-in
`timescale 1ns/1ps
`default_nettype none

module acc_trig_model (
  input wire logic clk_i,
  input wire logic [3:0] fire_i,
  input wire logic win_i,
  output acc_pkg::acc_ovf_t ovf_o,
  output logic win_o
);
  import acc_pkg::*;
  // Overflows are one-cycle pulses
  always_ff @(posedge clk_i) begin
    ovf_o <= fire_i;
    win_o <= win_i;
  end
endmodule
`default_nettype wire

// file: dv/acc_conv_ctrl_test.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none

module acc_conv_ctrl_test;
  import acc_pkg::*;
  localparam int DIV = 2;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ext = 0, win = 0;
  logic [7:0] adr = 0, q;
  logic [31:0] wdat = 0, rdat;
  logic [3:0] fire = 0;
  logic ack, shut, trk, cnv, done, wm;
  acc_ovf_t ovf;
  int bad_count = 0, n_checks = 0;
  acc_conv_ctrl #(.SAR_DIV(DIV), .CONV_CLKS(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'h1), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_ovf_i(ovf), .ext_start_i(ext), .win_match_i(wm), .shutdown_o(shut),
    .track_o(trk), .convert_o(cnv), .conv_done_o(done));
  acc_trig_model TRIG (.clk_i(clk_i), .fire_i(fire), .win_i(win), .ovf_o(ovf), .win_o(wm));
  // ==========
  // Helpers
  function automatic logic [7:0] after_conv(logic [7:0] r, logic w);
    return {r[7:6], 1'b1, 1'b0, r[3] | w, r[2:0]};
  endfunction
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // Wishbone classic cycle, held until ack
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 0;
    stb <= 0;
    chk("ack wait", 8'h2, 8'(n));
    @(posedge clk_i);
  endtask
  task automatic pulse(logic [3:0] m);
    @(posedge clk_i);
    fire <= m;
    @(posedge clk_i);
    fire <= 0;
  endtask
  task automatic wait_done();
    int n;
    for (n = 0; n < 40 && done !== 1'b1; n++) @(negedge clk_i);
    chk("done", 8'h1, 8'(done));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========
  // Clock and watchdog
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
  // ==========
  // Scenarios
  initial begin
    int n;
    logic [2:0] src [4];
    logic [3:0] tmr [4];
    void'($urandom(32'h3761719a));
    src = '{3'h1, 3'h2, 3'h3, 3'h5};
    tmr = '{4'h1, 4'h4, 4'h2, 4'h8};
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 8'h00, 8'h00);
    chk("reset", 8'h00, q);
    chk("shutdown", 8'h1, 8'(shut));
    bus(1, 8'h00, 8'h80);
    chk("track", 8'h1, 8'(trk));
    bus(1, 8'h04, 8'hff);
    bus(0, 8'h04, 8'h00);
    chk("unmapped", 8'h00, q);
    win <= 1'($urandom);
    bus(1, 8'h00, 8'h90);
    bus(0, 8'h00, 8'h00);
    chk("busy", 8'h90, q);
    wait_done();
    bus(0, 8'h00, 8'h00);
    chk("flags", after_conv(8'h90, win), q);
    bus(1, 8'h00, 8'ha8);
    bus(0, 8'h00, 8'h00);
    chk("sticky", after_conv(8'h90, win), q);
    bus(1, 8'h00, 8'h80);
    bus(0, 8'h00, 8'h00);
    chk("cleared", 8'h80, q);
    for (int i = 0; i < 4; i++) begin
      bus(1, 8'h00, {5'h10, src[i]});
      pulse(4'hf ^ tmr[i]);
      repeat (3) @(posedge clk_i);
      chk("other timer", 8'h0, 8'(cnv));
      pulse(tmr[i]);
      wait_done();
    end
    bus(1, 8'h00, 8'h95);
    repeat (3) @(posedge clk_i);
    chk("busy src", 8'h0, 8'(cnv));
    for (int j = 6; j < 8; j++) begin
      bus(1, 8'h00, {5'h10, 3'(j)});
      pulse(4'hf);
      repeat (3) @(posedge clk_i);
      chk("reserved", 8'h0, 8'(cnv));
    end
    bus(1, 8'h00, 8'hc1);
    chk("lp idle", 8'h0, 8'(trk));
    pulse(4'h1);
    for (n = 0; n < 20 && trk !== 1'b1; n++) @(negedge clk_i);
    for (n = 0; n < 20 && trk === 1'b1; n++) @(negedge clk_i);
    chk("track len", 8'(3 * DIV), 8'(n));
    chk("conv after", 8'h1, 8'(cnv));
    wait_done();
    bus(1, 8'h00, 8'hc4);
    chk("pin low", 8'h1, 8'(trk));
    @(posedge clk_i);
    ext <= 1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("pin rise", 8'h1, 8'(cnv));
    wait_done();
    bus(1, 8'h00, 8'h80);
    bus(1, 8'h00, 8'h90);
    chk("abort run", 8'h1, 8'(cnv));
    bus(1, 8'h00, 8'h00);
    chk("abort", 8'h0, 8'(cnv));
    bus(0, 8'h00, 8'h00);
    chk("no flag", 8'h00, q);
    bus(1, 8'h00, 8'h87);
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 8'h00, 8'h00);
    chk("reset again", 8'h00, q);
    chk("shutdown again", 8'h1, 8'(shut));
    conclude();
  end
endmodule
`default_nettype wire
